// [tpwm_params.svh]
// Purpose: Constants for the 16-bit timer PWM waveform block.
// Assumes: Included by the package and the design file.
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave.
`ifndef TPWM_PARAMS_SVH
`define TPWM_PARAMS_SVH
`define TPWM_OFF_CTRL      4'h0
`define TPWM_OFF_CMPA      4'h4
`define TPWM_OFF_CMPB      4'h8
`define TPWM_OFF_CAPT      4'hC
`define TPWM_OFF_COUNT     5'h10
`define TPWM_OFF_FLAGS     5'h14
`define TPWM_TOP8          16'h00FF
`define TPWM_TOP9          16'h01FF
`define TPWM_TOP10         16'h03FF
`define TPWM_MAX           16'hFFFF
`define TPWM_BOTTOM        16'h0000
`define TPWM_WGM_F8        4'h5
`define TPWM_WGM_F9        4'h6
`define TPWM_WGM_F10       4'h7
`define TPWM_WGM_FICR      4'hE
`define TPWM_WGM_FOCR      4'hF
`define TPWM_WGM_P8        4'h1
`define TPWM_WGM_P9        4'h2
`define TPWM_WGM_P10       4'h3
`define TPWM_WGM_PICR      4'hA
`define TPWM_WGM_POCR      4'hB
`define TPWM_COM_OFF       2'h0
`define TPWM_COM_TOG       2'h1
`define TPWM_COM_NINV      2'h2
`define TPWM_COM_INV       2'h3
`define TPWM_PS_1          3'h1
`define TPWM_PS_8          3'h2
`define TPWM_PS_64         3'h3
`define TPWM_PS_256        3'h4
`define TPWM_PS_1024       3'h5
`define TPWM_DIV_8         10'h007
`define TPWM_DIV_64        10'h03F
`define TPWM_DIV_256       10'h0FF
`define TPWM_DIV_1024      10'h3FF
`define TPWM_RESP_OKAY     2'h0
`define TPWM_RESP_SLVERR   2'h2
`endif

// [tpwm_pkg.sv]
// Purpose: Types for the 16-bit timer PWM waveform block.
// Assumes: tpwm_params.svh holds the numeric constants.
// Notes:   Control register layout is a packed struct.
`include "tpwm_params.svh"
package tpwm_pkg;
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [3:0] wgm;
    logic [2:0] clk_sel;
  } tpwm_ctrl_t;
  typedef struct packed {
    logic capt;
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tpwm_flags_t;
endpackage : tpwm_pkg

// [tpwm_timer.sv]
// Purpose: Fast and phase correct PWM generation for a 16-bit timer, AXI4-Lite slave.
// Assumes: One clock, synchronous active high reset, one outstanding access per direction.
// Notes:   Flags are cleared by writing one to their bit in the flag register.
// Function
// [RQ1] Single-slope modes pick fixed, capture or compare-A TOP; clear after TOP.
// [RQ2] Single-slope modes set the overflow flag whenever the count reaches TOP.
// [RQ3] Register-defined TOP sets compare-A or capture flag with the overflow flag.
// [RQ4] Fixed TOP masks compare bits above resolution when compare registers are written.
// [RQ5] Capture TOP register updates at once; a missed TOP runs to max and wraps.
// [RQ6] Single-slope compare writes go to a buffer loaded at TOP.
// [RQ7] Output mode two gives non-inverted, three gives inverted PWM.
// [RQ8] Single-slope: set on match, clear at TOP to BOTTOM; inverted opposite.
// [RQ9] Waveform reaches the pin only when its direction bit selects output.
// [RQ10] Compare zero gives one-cycle spike; compare at TOP gives constant level.
// [RQ11] Mode fifteen with channel A mode one toggles A on each match.
// [RQ12] Dual-slope modes count up from zero to TOP then down to BOTTOM.
// [RQ13] Dual-slope modes pick fixed, capture or compare-A TOP values.
// [RQ14] Dual-slope count holds TOP for one timer clock then counts down.
// [RQ15] Dual-slope: clear on up match, set on down match; inverted opposite.
// [RQ16] Dual-slope modes set the overflow flag whenever the count reaches BOTTOM.
// [RQ17] Dual-slope compare buffers load at TOP with the TOP-defining flag.
// [RQ18] Dual-slope compare at BOTTOM holds low, at TOP holds high.
// [RQ19] Mode eleven with channel A mode one toggles A for half duty.
// [RQ20] Software keeps register-defined TOP between three and the 16-bit maximum.
// [RQ21] Software keeps TOP at or above every compare register.
// [RQ22] Timer clock enable comes from a prescaler of 1, 8, 64, 256 or 1024.
// [RQ23] Software should prefer frequency correct mode when changing TOP live.
// [RQ24] Output mode zero performs no action on the compare output.
// [RQ25] Counter steps only in cycles where the timer clock enable is high.
// [RQ26] Flags stay set until software clears them.
`include "tpwm_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tpwm_timer #(
  parameter int CW = 16
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic [4:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [4:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        DIR_A,
  input  wire logic        DIR_B,
  output logic             PIN_A_O,
  output logic             PIN_A_OE,
  output logic             PIN_B_O,
  output logic             PIN_B_OE
);
  import tpwm_pkg::*;

  if (CW != 16) begin : g_cw_check
    $error("tpwm_timer supports only a 16-bit counter");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [4:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  tpwm_ctrl_t        ctrl_ff;
  tpwm_flags_t       flags_ff;
  tpwm_flags_t       nxt_flags;
  logic [CW-1:0]     cmpa_buf_ff;
  logic [CW-1:0]     cmpb_buf_ff;
  logic [CW-1:0]     cmpa_ff;
  logic [CW-1:0]     cmpb_ff;
  logic [CW-1:0]     capt_ff;
  logic [CW-1:0]     count_ff;
  logic [CW-1:0]     nxt_count;
  logic              down_ff;
  logic              nxt_down;
  logic              out_a_ff;
  logic              out_b_ff;
  logic              nxt_out_a;
  logic              nxt_out_b;
  logic [9:0]        pre_ff;

  wire aw_ok    = S_AXI_AWVALID && !aw_got_ff && !bvalid_ff;
  wire w_ok     = S_AXI_WVALID && !w_got_ff && !bvalid_ff;
  wire wr_fire  = (aw_got_ff || aw_ok) && (w_got_ff || w_ok);
  wire [4:0]  wa = aw_got_ff ? awaddr_ff : S_AXI_AWADDR;
  wire [31:0] wd = w_got_ff ? wdata_ff : S_AXI_WDATA;
  wire wr_ctrl  = wr_fire && (wa == {1'b0, `TPWM_OFF_CTRL});
  wire wr_cmpa  = wr_fire && (wa == {1'b0, `TPWM_OFF_CMPA});
  wire wr_cmpb  = wr_fire && (wa == {1'b0, `TPWM_OFF_CMPB});
  wire wr_capt  = wr_fire && (wa == {1'b0, `TPWM_OFF_CAPT});
  wire wr_flag  = wr_fire && (wa == `TPWM_OFF_FLAGS);
  wire wr_cnt   = wr_fire && (wa == `TPWM_OFF_COUNT);
  wire wr_map   = wr_ctrl || wr_cmpa || wr_cmpb || wr_capt || wr_flag || wr_cnt;
  wire rd_fire  = S_AXI_ARVALID && !rvalid_ff;

  assign S_AXI_AWREADY = aw_ok;
  assign S_AXI_WREADY  = w_ok;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = rd_fire;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;

  // ----------------------------------------------------------------
  // Mode decode and TOP selection
  // ----------------------------------------------------------------
  wire [3:0] wgm      = ctrl_ff.wgm;
  wire fast_fix       = (wgm == `TPWM_WGM_F8) || (wgm == `TPWM_WGM_F9) || (wgm == `TPWM_WGM_F10);
  wire pc_fix         = (wgm == `TPWM_WGM_P8) || (wgm == `TPWM_WGM_P9) || (wgm == `TPWM_WGM_P10);
  wire top_icr        = (wgm == `TPWM_WGM_FICR) || (wgm == `TPWM_WGM_PICR);
  wire top_ocr        = (wgm == `TPWM_WGM_FOCR) || (wgm == `TPWM_WGM_POCR);
  wire fast           = fast_fix || (wgm == `TPWM_WGM_FICR) || (wgm == `TPWM_WGM_FOCR);
  wire dual           = pc_fix || (wgm == `TPWM_WGM_PICR) || (wgm == `TPWM_WGM_POCR); // RQ12
  wire [1:0] res_sel  = wgm[1:0];
  wire [CW-1:0] fix_top = (res_sel == 2'h1) ? `TPWM_TOP8 :
                          (res_sel == 2'h2) ? `TPWM_TOP9 : `TPWM_TOP10; // RQ1 RQ13
  wire [CW-1:0] top   = top_icr ? capt_ff : top_ocr ? cmpa_ff :
                        (fast_fix || pc_fix) ? fix_top : `TPWM_MAX; // RQ1 RQ13 RQ5
  wire [CW-1:0] wmask = (fast_fix || pc_fix) ? fix_top : `TPWM_MAX; // RQ4

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  wire [9:0] div_lim  = (ctrl_ff.clk_sel == `TPWM_PS_8)   ? `TPWM_DIV_8 :
                        (ctrl_ff.clk_sel == `TPWM_PS_64)  ? `TPWM_DIV_64 :
                        (ctrl_ff.clk_sel == `TPWM_PS_256) ? `TPWM_DIV_256 : `TPWM_DIV_1024;
  wire ps_run         = (ctrl_ff.clk_sel >= `TPWM_PS_1) && (ctrl_ff.clk_sel <= `TPWM_PS_1024);
  wire tick           = ps_run && ((ctrl_ff.clk_sel == `TPWM_PS_1) || (pre_ff >= div_lim)); // RQ22

  // ----------------------------------------------------------------
  // Counter, matches and waveform
  // ----------------------------------------------------------------
  wire at_top   = (count_ff == top);
  wire at_bot   = (count_ff == `TPWM_BOTTOM);
  wire match_a  = (count_ff == cmpa_ff);
  wire match_b  = (count_ff == cmpb_ff);
  wire pwm_on   = fast || dual;
  wire fast_top = fast && at_top;
  wire dual_top = dual && at_top && !down_ff;
  wire load_buf = fast_top || dual_top; // RQ6 RQ17

  always_comb begin
    nxt_down  = down_ff;
    nxt_count = count_ff + 16'h0001; // RQ5
    if (fast && at_top) begin
      nxt_count = `TPWM_BOTTOM; // RQ1
    end else if (dual) begin
      if (!down_ff && at_top) begin
        nxt_down  = 1'b1; // RQ14
        nxt_count = count_ff - 16'h0001;
      end else if (down_ff && at_bot) begin
        nxt_down  = 1'b0;
        nxt_count = count_ff + 16'h0001;
      end else if (down_ff) begin
        nxt_count = count_ff - 16'h0001; // RQ12
      end
    end
  end

  function automatic logic wave(input logic cur, input logic [1:0] com, input logic m,
                                input logic tog_ok, input logic up, input logic restart);
    logic r;
    r = cur;
    if (com == `TPWM_COM_TOG) begin
      if (tog_ok && m) r = ~cur; // RQ11 RQ19
    end else if (com == `TPWM_COM_NINV || com == `TPWM_COM_INV) begin
      if (restart) r = (com == `TPWM_COM_INV); // RQ8
      if (m) r = (com == `TPWM_COM_NINV) ? ~up : up; // RQ7 RQ15 RQ10 RQ18
    end
    return r; // RQ24
  endfunction

  wire tog_ok   = top_ocr;
  wire up_ph    = dual ? (down_ff ? at_bot : !at_top) : 1'b1; // RQ18
  wire f_a      = fast ? 1'b0 : up_ph;
  assign nxt_out_a = pwm_on ? wave(out_a_ff, ctrl_ff.com_a, match_a, tog_ok,
                                   f_a, fast_top && !match_a) : out_a_ff;
  assign nxt_out_b = pwm_on ? wave(out_b_ff, (ctrl_ff.com_b == `TPWM_COM_TOG) ?
                                   `TPWM_COM_OFF : ctrl_ff.com_b, match_b, 1'b0,
                                   f_a, fast_top && !match_b) : out_b_ff;

  assign PIN_A_O  = out_a_ff;
  assign PIN_B_O  = out_b_ff;
  assign PIN_A_OE = DIR_A && (ctrl_ff.com_a != `TPWM_COM_OFF); // RQ9
  assign PIN_B_OE = DIR_B && (ctrl_ff.com_b != `TPWM_COM_OFF); // RQ9

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire set_ovf  = tick && ((fast && at_top) || (dual && at_bot && down_ff)); // RQ2 RQ16
  wire set_a    = tick && pwm_on && (match_a || (top_ocr && load_buf)); // RQ3 RQ17
  wire set_b    = tick && pwm_on && match_b;
  wire set_c    = tick && top_icr && load_buf; // RQ3 RQ17
  wire [3:0] clr = wr_flag ? wd[3:0] : 4'h0;
  assign nxt_flags = tpwm_flags_t'((flags_ff & ~clr) | {set_c, set_b, set_a, set_ovf}); // RQ26

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= tick ? 10'h000 : (ps_run ? pre_ff + 10'h001 : 10'h000);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      count_ff <= `TPWM_BOTTOM;
      down_ff  <= 1'b0;
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
      cmpa_ff  <= `TPWM_BOTTOM;
      cmpb_ff  <= `TPWM_BOTTOM;
    end else begin
      if (wr_cnt) begin
        count_ff <= wd[CW-1:0];
      end else if (tick) begin
        count_ff <= nxt_count; // RQ25
        down_ff  <= nxt_down;
        out_a_ff <= nxt_out_a;
        out_b_ff <= nxt_out_b;
      end
      if (!pwm_on || (tick && load_buf)) begin
        cmpa_ff <= cmpa_buf_ff; // RQ6 RQ17
        cmpb_ff <= cmpb_buf_ff;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_ff     <= '0;
      cmpa_buf_ff <= `TPWM_BOTTOM;
      cmpb_buf_ff <= `TPWM_BOTTOM;
      capt_ff     <= `TPWM_BOTTOM;
      flags_ff    <= '0;
    end else begin
      flags_ff <= nxt_flags;
      if (wr_ctrl) ctrl_ff <= tpwm_ctrl_t'(wd[10:0]);
      if (wr_cmpa) cmpa_buf_ff <= wd[CW-1:0] & wmask; // RQ4
      if (wr_cmpb) cmpb_buf_ff <= wd[CW-1:0] & wmask; // RQ4
      if (wr_capt) capt_ff <= wd[CW-1:0]; // RQ5
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 5'h00;
      wdata_ff  <= 32'h0000_0000;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `TPWM_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
      end else begin
        if (aw_ok) aw_got_ff <= 1'b1;
        if (w_ok) w_got_ff <= 1'b1;
        if (bvalid_ff && S_AXI_BREADY) bvalid_ff <= 1'b0;
      end
      if (aw_ok) awaddr_ff <= S_AXI_AWADDR;
      if (w_ok) wdata_ff <= S_AXI_WDATA;
    end
  end

  wire [4:0] ra = S_AXI_ARADDR;
  wire [31:0] rmux = (ra == {1'b0, `TPWM_OFF_CTRL}) ? {21'h0, ctrl_ff} :
                     (ra == {1'b0, `TPWM_OFF_CMPA}) ? {16'h0, cmpa_buf_ff} :
                     (ra == {1'b0, `TPWM_OFF_CMPB}) ? {16'h0, cmpb_buf_ff} :
                     (ra == {1'b0, `TPWM_OFF_CAPT}) ? {16'h0, capt_ff} :
                     (ra == `TPWM_OFF_COUNT) ? {16'h0, count_ff} :
                     (ra == `TPWM_OFF_FLAGS) ? {28'h0, flags_ff} : 32'h0000_0000;
  wire rd_map = (ra[1:0] == 2'h0) && (ra <= `TPWM_OFF_FLAGS);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `TPWM_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rmux;
      rresp_ff  <= rd_map ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence fast_wrap_s;
    tick && fast && at_top;
  endsequence

  fast_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ1
    (fast_wrap_s and (!wr_cnt)) |=> count_ff == `TPWM_BOTTOM)
    else $error("fast counter did not clear after TOP");
  fast_ovf_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ2
    fast_wrap_s |=> flags_ff.ovf)
    else $error("overflow flag missing at TOP");
  top_flag_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ3
    (fast_wrap_s and top_ocr) |=> flags_ff.cmp_a && flags_ff.ovf)
    else $error("compare A flag not set with overflow");
  buf_load_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ6
    (fast_wrap_s and (!wr_ctrl)) |=> cmpa_ff == $past(cmpa_buf_ff))
    else $error("compare A not loaded from buffer at TOP");
  mask_wr_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ4
    wr_cmpa && fast_fix |=> (cmpa_buf_ff & ~$past(wmask)) == 16'h0000)
    else $error("compare bits above resolution not masked");
  dual_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ14
    tick && dual && at_top && !down_ff && !wr_cnt |=> down_ff && count_ff == $past(count_ff) - 16'h0001)
    else $error("dual slope did not reverse after TOP");
  dual_ovf_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ16
    tick && dual && at_bot && down_ff |=> flags_ff.ovf)
    else $error("overflow flag missing at BOTTOM");
  pin_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ9
    !DIR_A |-> !PIN_A_OE)
    else $error("pin driven while direction is input");
  flag_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ26
    flags_ff.ovf && !wr_flag |=> flags_ff.ovf)
    else $error("overflow flag dropped without clear");
  hold_tick_a: assert property (@(posedge REF_CLK) disable iff (RESET) // RQ25
    !tick && !wr_cnt |=> $stable(count_ff))
    else $error("counter moved without timer clock enable");
endmodule : tpwm_timer
`default_nettype wire

// [tpwm_timer_tb.sv]
// Purpose: Self-checking bench for the timer PWM block over AXI4-Lite.
// Assumes: Register map and handshake timing as handed over by the designer.
// Notes:   Duty is counted over whole periods and compared with a model.
`include "tpwm_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tpwm_timer_tb;
  import tpwm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  awaddr = '0;
  logic [4:0]  araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        dir_a = 1'b0, dir_b = 1'b0;
  logic        pin_a, pin_a_oe, pin_b, pin_b_oe;
  int          error_cnt = 0;
  int          n_tests = 0;
  integer      seed = 32'hcba6_228c;
  int t_wgm[14] = '{5, 6, 7, 14, 14, 14, 15, 1, 2, 3, 10, 10, 10, 11};
  int t_ca[14]  = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 1};
  int t_cb[14]  = '{2, 3, 2, 2, 3, 2, 0, 2, 3, 2, 2, 2, 3, 0};
  int t_top[14] = '{255, 511, 1023, 7, 7, 9, 5, 255, 511, 1023, 7, 7, 7, 5};
  int t_cmp[14] = '{-1, -1, -1, 3, 7, 9, 2, -1, -1, -1, 0, 7, 3, 2};
  int dv[6]     = '{0, 1, 8, 64, 256, 1024};
  int fm[6]     = '{5, 6, 7, 1, 2, 3};
  logic [15:0] ft[6] = '{`TPWM_TOP8, `TPWM_TOP9, `TPWM_TOP10, `TPWM_TOP8, `TPWM_TOP9, `TPWM_TOP10};

  always #5 clk = ~clk;

  tpwm_timer u_dut (
    .REF_CLK(clk), .RESET(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DIR_A(dir_a), .DIR_B(dir_b), .PIN_A_O(pin_a), .PIN_A_OE(pin_a_oe),
    .PIN_B_O(pin_b), .PIN_B_OE(pin_b_oe)
  );

  // ----------------------------------------------------------------
  // Checking, bus tasks and model.
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 1000) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1'b1;
        bready <= 1'b0;
        chk("write response", er, bresp);
      end
      n++;
    end
    if (!done) chk("write answered", 1, 0);
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 1000) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
      n++;
    end
    if (!done) chk("read answered", 1, 0);
    @(posedge clk);
  endtask : rd

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("read response", `TPWM_RESP_OKAY, r);
  endtask : rdc

  function automatic int exp_high(int wgm, int com, int top, int cmp);
    int per;
    int h;
    logic fast;
    fast = wgm inside {5, 6, 7, 14, 15};
    per = fast ? top + 1 : 2 * top;
    if (com == 1) h = per / 2;
    else if (fast) h = (cmp == top) ? per : top - cmp;
    else h = 2 * cmp;
    if (com == 3) h = per - h;
    return h;
  endfunction : exp_high

  task automatic run_case(int wgm, int ca, int cb, int top, int cmp, int ps, int div);
    tpwm_ctrl_t c;
    int per, hi;
    logic [3:0] m, e;
    logic b0;
    logic [31:0] d;
    logic [1:0] r;
    per = (wgm inside {5, 6, 7, 14, 15}) ? top + 1 : 2 * top;
    c = '0;
    wr(`TPWM_OFF_CTRL, 32'h0000_0000, `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_COUNT, 32'h0000_0000, `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_CAPT, 32'(top), `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_CMPA, 32'((ca == 1) ? top : cmp), `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_CMPB, 32'(cmp), `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_FLAGS, 32'h0000_000F, `TPWM_RESP_OKAY);
    c.com_a = 2'(ca);
    c.com_b = 2'(cb);
    c.wgm = 4'(wgm);
    c.clk_sel = 3'(ps);
    wr(`TPWM_OFF_CTRL, 32'(c), `TPWM_RESP_OKAY);
    dir_a <= 1'($random(seed));
    dir_b <= 1'($random(seed));
    repeat (per * div) @(posedge clk);
    b0 = pin_b;
    hi = 0;
    repeat (2 * per * div) begin
      @(negedge clk);
      if ((ca == 1) ? (pin_a === 1'b1) : (pin_b === 1'b1)) hi++;
    end
    chk("pin a enable", dir_a && ca != 0, pin_a_oe);
    chk("pin b enable", dir_b && cb != 0, pin_b_oe);
    if (cb == 0) chk("pin b held", b0, pin_b);
    @(posedge clk);
    chk("high cycles", 2 * div * exp_high(wgm, (ca == 1) ? ca : cb, top, cmp), hi);
    wr(`TPWM_OFF_CTRL, 32'h0000_0000, `TPWM_RESP_OKAY);
    rd(`TPWM_OFF_FLAGS, d, r);
    m = (wgm == 15 || wgm == 11) ? 4'hF : 4'hD;
    e = {wgm == 14 || wgm == 10, 1'b1, wgm == 15 || wgm == 11, 1'b1};
    chk("flags", e, d[3:0] & m);
    wr(`TPWM_OFF_FLAGS, 32'h0000_000F, `TPWM_RESP_OKAY);
    rdc("flags cleared", `TPWM_OFF_FLAGS, 32'h0000_0000);
  endtask : run_case

  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  initial begin
    tpwm_ctrl_t c;
    logic [31:0] d, d2;
    logic [1:0] r;
    int cmp;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl reset", `TPWM_OFF_CTRL, 32'h0000_0000);
    rdc("count reset", `TPWM_OFF_COUNT, 32'h0000_0000);
    rdc("flags reset", `TPWM_OFF_FLAGS, 32'h0000_0000);
    rdc("capture reset", `TPWM_OFF_CAPT, 32'h0000_0000);
    rd(5'h18, d, r);
    chk("unmapped read data", 32'h0000_0000, d);
    chk("unmapped read response", `TPWM_RESP_SLVERR, r);
    wr(5'h18, 32'h0000_1234, `TPWM_RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      c = '0;
      c.wgm = 4'(fm[i]);
      wr(`TPWM_OFF_CTRL, 32'(c), `TPWM_RESP_OKAY);
      wr(`TPWM_OFF_CMPB, 32'h0000_FFFF, `TPWM_RESP_OKAY);
      wr(`TPWM_OFF_CMPA, 32'h0000_FFFF, `TPWM_RESP_OKAY);
      rdc("masked compare b", `TPWM_OFF_CMPB, {16'h0000, ft[i]});
      rdc("masked compare a", `TPWM_OFF_CMPA, {16'h0000, ft[i]});
    end
    for (int i = 0; i < 14; i++) begin
      cmp = (t_cmp[i] < 0) ? int'($unsigned($random(seed)) % (t_top[i] + 1)) : t_cmp[i];
      run_case(t_wgm[i], t_ca[i], t_cb[i], t_top[i], cmp, 1, 1);
    end
    for (int p = 2; p <= 5; p++) run_case(14, 0, 2, 7, 3, p, dv[p]);
    c = '0;
    c.wgm = `TPWM_WGM_FICR;
    c.clk_sel = `TPWM_PS_1;
    wr(`TPWM_OFF_COUNT, 32'h0000_FFF0, `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_CAPT, 32'h0000_0007, `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_CTRL, 32'(c), `TPWM_RESP_OKAY);
    wr(`TPWM_OFF_CTRL, 32'h0000_0000, `TPWM_RESP_OKAY);
    rd(`TPWM_OFF_COUNT, d, r);
    chk("count runs past lower top", 1, d[15:0] >= 16'hFFF0);
    repeat (20) @(posedge clk);
    rd(`TPWM_OFF_COUNT, d2, r);
    chk("count holds while stopped", d, d2);
    wr(`TPWM_OFF_CTRL, 32'(c), `TPWM_RESP_OKAY);
    repeat (40) @(posedge clk);
    wr(`TPWM_OFF_CTRL, 32'h0000_0000, `TPWM_RESP_OKAY);
    rd(`TPWM_OFF_COUNT, d, r);
    chk("count wrapped under top", 1, d[15:0] <= 16'h0007);
    rd(`TPWM_OFF_FLAGS, d, r);
    chk("flags after wrap", 4'h9, d[3:0] & 4'h9);
    print_verdict();
  end

  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule : tpwm_timer_tb
`default_nettype wire
